// ===== uip_irq_ctrl.v
// interrupt mask, source encoding, queue control and line status for one channel
`timescale 1ns/1ns
`include "uip_defines.vh"
module uip_irq_ctrl (
  input wire core_clk,
  input wire rst_b,
  input wire ce,
  input wire bus_cs_b,
  input wire bus_rd_b,
  input wire bus_wr_b,
  input wire [2:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire divisor_sel,
  input wire enh_enable,
  input wire auto_cts_en,
  input wire auto_rts_en,
  input wire rx_char_loaded,
  input wire rx_head_load,
  input wire rx_empty,
  input wire rx_at_trigger,
  input wire [2:0] rx_head_err,
  input wire rx_fifo_err,
  input wire overrun_evt,
  input wire thr_empty,
  input wire tsr_empty,
  input wire tx_below_trigger,
  input wire tx_fifo_empty,
  input wire [3:0] modem_delta,
  input wire xoff_detect,
  input wire xon_detect,
  input wire special_detect,
  input wire cts_rise,
  input wire rts_rise,
  input wire bit_tick,
  input wire [3:0] char_bits,
  output reg [7:0] read_data,
  output reg read_hit,
  output reg irq,
  output reg fifo_enable,
  output reg rx_fifo_reset,
  output reg tx_fifo_reset,
  output reg dma_mode,
  output reg [1:0] rx_trig_sel,
  output reg [1:0] tx_trig_sel,
  output wire sleep_enable,
  output wire rx_read_pulse,
  output wire tx_write_pulse,
  output wire line_status_read,
  output wire modem_status_read
);
  // ------------------------------------------------
  // bus pin synchroniser
  // ------------------------------------------------
  reg [13:0] sync_1;
  reg [13:0] sync_2;
  reg rd_q;
  reg wr_q;
  wire cs_s;
  wire rd_s;
  wire wr_s;
  wire [2:0] addr_s;
  wire [7:0] wdata_s;
  wire rd_take;
  wire wr_take;
  wire bank_ok;

  assign cs_s = sync_2[13];
  assign rd_s = sync_2[12];
  assign wr_s = sync_2[11];
  assign addr_s = sync_2[10:8];
  assign wdata_s = sync_2[7:0];
  // host must hold address and data stable while a strobe is low
  assign rd_take = !cs_s && !rd_s && rd_q;
  assign wr_take = !cs_s && !wr_s && wr_q;
  // divisor latches share the low three addresses
  assign bank_ok = !divisor_sel;

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync_1 <= `UIP_SYNC_RST;
      sync_2 <= `UIP_SYNC_RST;
      rd_q <= 1'b1;
      wr_q <= 1'b1;
    end
    else if (ce)
    begin
      sync_1 <= {bus_cs_b, bus_rd_b, bus_wr_b, bus_addr, bus_wdata};
      sync_2 <= sync_1;
      rd_q <= rd_s;
      wr_q <= wr_s;
    end
  end

  // ------------------------------------------------
  // access decode
  // ------------------------------------------------
  wire mask_wr;
  wire qc_wr;
  wire src_rd;
  assign mask_wr = wr_take && bank_ok && addr_s == `UIP_ADDR_MASK;
  assign qc_wr = wr_take && bank_ok && addr_s == `UIP_ADDR_SRC;
  assign src_rd = rd_take && bank_ok && addr_s == `UIP_ADDR_SRC;
  assign rx_read_pulse = rd_take && bank_ok && addr_s == `UIP_ADDR_RXTX;
  assign tx_write_pulse = wr_take && bank_ok && addr_s == `UIP_ADDR_RXTX;
  assign line_status_read = rd_take && addr_s == `UIP_ADDR_LINE;
  assign modem_status_read = rd_take && addr_s == `UIP_ADDR_MODEM;

  // ------------------------------------------------
  // interrupt mask and queue control
  // ------------------------------------------------
  reg [7:0] interrupt_mask;
  wire [7:0] mask_eff;
  // upper enables are held but act only with enhanced functions on
  assign mask_eff = {interrupt_mask[7:4] & {4{enh_enable}}, interrupt_mask[3:0]};
  assign sleep_enable = mask_eff[`UIP_MASK_SLEEP];

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      interrupt_mask <= `UIP_MASK_RST;
      fifo_enable <= 1'b0;
      rx_fifo_reset <= 1'b0;
      tx_fifo_reset <= 1'b0;
      dma_mode <= 1'b0;
      rx_trig_sel <= 2'h0;
      tx_trig_sel <= 2'h0;
    end
    else if (ce)
    begin
      rx_fifo_reset <= 1'b0;
      tx_fifo_reset <= 1'b0;
      if (mask_wr)
        interrupt_mask <= wdata_s;
      if (qc_wr)
      begin
        fifo_enable <= wdata_s[`UIP_QC_EN];
        if (wdata_s[`UIP_QC_EN])
        begin
          rx_fifo_reset <= wdata_s[`UIP_QC_RXRST];
          tx_fifo_reset <= wdata_s[`UIP_QC_TXRST];
          dma_mode <= wdata_s[`UIP_QC_DMA];
          rx_trig_sel <= wdata_s[7:6];
          if (enh_enable)
            tx_trig_sel <= wdata_s[5:4];
        end
      end
    end
  end

  // ------------------------------------------------
  // line status
  // ------------------------------------------------
  reg data_ready;
  reg overrun_flag;
  reg ls_flag;
  wire [7:0] line_status;
  assign line_status = {rx_fifo_err, thr_empty && tsr_empty, thr_empty, rx_head_err,
                        overrun_flag, data_ready};

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      data_ready <= 1'b0;
      overrun_flag <= 1'b0;
      ls_flag <= 1'b0;
    end
    else if (ce)
    begin
      if (rx_char_loaded)
        data_ready <= 1'b1;
      else if (rx_empty)
        data_ready <= 1'b0;
      if (overrun_evt)
        overrun_flag <= 1'b1;
      else if (line_status_read)
        overrun_flag <= 1'b0;
      if (overrun_evt || (rx_head_load && |rx_head_err))
        ls_flag <= 1'b1;
      else if (line_status_read)
        ls_flag <= 1'b0;
    end
  end

  // ------------------------------------------------
  // transmit, match and flow flags
  // ------------------------------------------------
  reg tx_cond_q;
  reg tx_flag;
  reg xoff_flag;
  reg spec_flag;
  reg cts_flag;
  reg rts_flag;
  reg [6:0] cur_src;
  wire tx_cond;
  wire tx_mask_rise;
  wire src_rd_xoff;
  assign tx_cond = fifo_enable ? (tx_below_trigger || tx_fifo_empty) : thr_empty;
  assign tx_mask_rise = mask_wr && wdata_s[`UIP_MASK_TX] && !interrupt_mask[`UIP_MASK_TX];
  assign src_rd_xoff = src_rd && cur_src[`UIP_SRC_XOFF];

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_cond_q <= 1'b0;
      tx_flag <= 1'b0;
      xoff_flag <= 1'b0;
      spec_flag <= 1'b0;
      cts_flag <= 1'b0;
      rts_flag <= 1'b0;
    end
    else if (ce)
    begin
      tx_cond_q <= tx_cond;
      if ((tx_cond && !tx_cond_q) || (tx_mask_rise && tx_cond))
        tx_flag <= 1'b1;
      else if (tx_write_pulse || (src_rd && cur_src[`UIP_SRC_TX]))
        tx_flag <= 1'b0;
      if (xoff_detect && enh_enable)
        xoff_flag <= 1'b1;
      else if (src_rd_xoff || xon_detect)
        xoff_flag <= 1'b0;
      if (special_detect && enh_enable)
        spec_flag <= 1'b1;
      else if (src_rd_xoff || rx_char_loaded)
        spec_flag <= 1'b0;
      if (cts_rise && auto_cts_en)
        cts_flag <= 1'b1;
      else if (modem_status_read)
        cts_flag <= 1'b0;
      if (rts_rise && auto_rts_en)
        rts_flag <= 1'b1;
      else if (modem_status_read)
        rts_flag <= 1'b0;
    end
  end

  // ------------------------------------------------
  // time-out timer
  // ------------------------------------------------
  wire to_flag;
  uip_rx_timeout u_timeout (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ce(ce),
    .enable(fifo_enable),
    .data_present(!rx_empty),
    .restart(rx_char_loaded || rx_read_pulse),
    .clear(rx_read_pulse),
    .bit_tick(bit_tick),
    .char_bits(char_bits),
    .timeout_flag(to_flag)
  );

  // ------------------------------------------------
  // pending sources and priority
  // ------------------------------------------------
  // with all four basic enables clear and no upper enable active only polling of line status remains
  wire [6:0] pend;
  wire [6:0] pick;
  wire [5:0] code;
  wire [6:0] next_cur;
  assign pend[`UIP_SRC_LS] = ls_flag && mask_eff[`UIP_MASK_LS];
  assign pend[`UIP_SRC_TO] = to_flag && mask_eff[`UIP_MASK_RX];
  assign pend[`UIP_SRC_RX] = mask_eff[`UIP_MASK_RX] &&
                             (fifo_enable ? rx_at_trigger : !rx_empty);
  assign pend[`UIP_SRC_TX] = tx_flag && mask_eff[`UIP_MASK_TX];
  assign pend[`UIP_SRC_MS] = |modem_delta && mask_eff[`UIP_MASK_MS];
  assign pend[`UIP_SRC_XOFF] = (xoff_flag || spec_flag) && mask_eff[`UIP_MASK_XOFF];
  assign pend[`UIP_SRC_FLOW] = (cts_flag && mask_eff[`UIP_MASK_CTS]) ||
                               (rts_flag && mask_eff[`UIP_MASK_RTS]);

  uip_prio u_prio (
    .pend(pend),
    .sel(cur_src),
    .pick(pick),
    .code(code)
  );

  // the reported source stays until it is no longer pending
  assign next_cur = |(cur_src & pend) ? cur_src : pick;

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cur_src <= 7'h00;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      cur_src <= next_cur;
      irq <= |pend;
    end
  end

  // ------------------------------------------------
  // read data
  // ------------------------------------------------
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      read_data <= 8'h00;
      read_hit <= 1'b0;
    end
    else if (ce)
    begin
      read_hit <= 1'b0;
      if (rd_take)
      begin
        read_hit <= 1'b1;
        case (addr_s)
          `UIP_ADDR_MASK: read_data <= bank_ok ? mask_eff : 8'h00;
          `UIP_ADDR_SRC: read_data <= bank_ok ? {{2{fifo_enable}}, code} : 8'h00;
          `UIP_ADDR_LINE: read_data <= line_status;
          default:
          begin
            read_data <= 8'h00;
            read_hit <= 1'b0;
          end
        endcase
        if (!bank_ok && addr_s != `UIP_ADDR_LINE)
          read_hit <= 1'b0;
      end
    end
  end
endmodule // uip_irq_ctrl

// ===== uip_defines.vh
// constants of the uart interrupt prioritizer
// Behaviour
// - fifo mode: receive irq follows trigger level
// - data ready sets on load, clears empty
// - all basic enables off gives polled mode; enhanced upper enables still raise irq
// - line status bits zero to seven reported
// - non fifo: receive irq while holding full
// - transmit irq on empty; enabling raises immediately
// - overrun immediate; char errors at holding position
// - modem irq on any delta bit
// - upper mask bits need enhanced enable
// - cts or rts rise irq under auto flow
// - report highest source, hold until serviced
// - time-out after four chars plus twelve bits
// - xoff or special match irq, status bit four
// - line/modem status reads clear their irqs
// - rx ready below trigger; time-out on read
// - tx irq clears on status read, write
// - xoff clears on xon; special next char
// - flow change cleared by modem read, bit five
// - source codes in status bits five to zero
// - bit zero low while pending, reset high
// - bits seven six show fifo enable
// - fifo enable gates other control bits
`ifndef UIP_DEFINES_VH
`define UIP_DEFINES_VH
// ------------------------------------------------
// register addresses
// ------------------------------------------------
`define UIP_ADDR_RXTX 3'h0
`define UIP_ADDR_MASK 3'h1
`define UIP_ADDR_SRC 3'h2
`define UIP_ADDR_LINE 3'h5
`define UIP_ADDR_MODEM 3'h6
// ------------------------------------------------
// field positions
// ------------------------------------------------
`define UIP_MASK_RX 0
`define UIP_MASK_TX 1
`define UIP_MASK_LS 2
`define UIP_MASK_MS 3
`define UIP_MASK_SLEEP 4
`define UIP_MASK_XOFF 5
`define UIP_MASK_RTS 6
`define UIP_MASK_CTS 7
`define UIP_QC_EN 0
`define UIP_QC_RXRST 1
`define UIP_QC_TXRST 2
`define UIP_QC_DMA 3
// ------------------------------------------------
// source indices and status codes
// ------------------------------------------------
`define UIP_SRC_LS 0
`define UIP_SRC_TO 1
`define UIP_SRC_RX 2
`define UIP_SRC_TX 3
`define UIP_SRC_MS 4
`define UIP_SRC_XOFF 5
`define UIP_SRC_FLOW 6
`define UIP_CODE_LS 6'h06
`define UIP_CODE_TO 6'h0c
`define UIP_CODE_RX 6'h04
`define UIP_CODE_TX 6'h02
`define UIP_CODE_MS 6'h00
`define UIP_CODE_XOFF 6'h10
`define UIP_CODE_FLOW 6'h20
`define UIP_CODE_NONE 6'h01
// ------------------------------------------------
// reset values and timing
// ------------------------------------------------
`define UIP_MASK_RST 8'h00
`define UIP_SYNC_RST 14'h3800
`define UIP_TO_CHARS 7'h04
`define UIP_TO_BITS 7'h0c
`endif

// ===== uip_prio.v
// priority pick and status code encoding
`timescale 1ns/1ns
`include "uip_defines.vh"
module uip_prio (
  input wire [6:0] pend,
  input wire [6:0] sel,
  output wire [6:0] pick,
  output wire [5:0] code
);
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function [6:0] uip_first;
    input [6:0] v;
    integer i;
    begin
      uip_first = 7'h00;
      for (i = 6; i >= 0; i = i - 1)
        if (v[i])
          uip_first = 7'h00 | (7'h01 << i);
    end
  endfunction

  function [5:0] uip_code;
    input [6:0] s;
    begin
      case (s)
        7'h01: uip_code = `UIP_CODE_LS;
        7'h02: uip_code = `UIP_CODE_TO;
        7'h04: uip_code = `UIP_CODE_RX;
        7'h08: uip_code = `UIP_CODE_TX;
        7'h10: uip_code = `UIP_CODE_MS;
        7'h20: uip_code = `UIP_CODE_XOFF;
        7'h40: uip_code = `UIP_CODE_FLOW;
        default: uip_code = `UIP_CODE_NONE;
      endcase
    end
  endfunction

  assign pick = uip_first(pend);
  assign code = uip_code(sel);
endmodule // uip_prio

// ===== uip_rx_timeout.v
// receive time-out timer counted in bit times
`timescale 1ns/1ns
`include "uip_defines.vh"
module uip_rx_timeout (
  input wire core_clk,
  input wire rst_b,
  input wire ce,
  input wire enable,
  input wire data_present,
  input wire restart,
  input wire clear,
  input wire bit_tick,
  input wire [3:0] char_bits,
  output reg timeout_flag
);
  reg [6:0] count;
  wire [6:0] limit;
  // four characters plus twelve bits, in bit ticks
  assign limit = `UIP_TO_CHARS * {3'h0, char_bits} + `UIP_TO_BITS;
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count <= 7'h00;
      timeout_flag <= 1'b0;
    end
    else if (ce)
    begin
      if (restart || !data_present || !enable)
        count <= 7'h00;
      else if (bit_tick && count != limit)
        count <= count + 7'h01;
      // a read in the same cycle blocks the set and clears the flag
      if (enable && data_present && !restart && bit_tick && count + 7'h01 == limit)
        timeout_flag <= 1'b1;
      else if (clear || !enable)
        timeout_flag <= 1'b0;
    end
  end
endmodule // uip_rx_timeout

// ===== uip_irq_ctrl_assertions.sv
// port assertions of the interrupt prioritizer
`timescale 1ns/1ns
module uip_irq_ctrl_assertions (
  input wire core_clk,
  input wire rst_b,
  input wire bus_cs_b,
  input wire bus_rd_b,
  input wire bus_wr_b,
  input wire [2:0] bus_addr,
  input wire enh_enable,
  input wire [2:0] rx_head_err,
  input wire rx_fifo_err,
  input wire rx_empty,
  input wire thr_empty,
  input wire [7:0] read_data,
  input wire read_hit,
  input wire fifo_enable,
  input wire rx_fifo_reset,
  input wire tx_fifo_reset,
  input wire sleep_enable,
  input wire tx_write_pulse,
  input wire line_status_read,
  input wire modem_status_read
);
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_answer;
    read_hit ##1 !read_hit;
  endsequence
  sequence s_ls_fields;
    read_data[7] == $past(rx_fifo_err) && read_data[5] == $past(thr_empty) &&
      read_data[4:2] == $past(rx_head_err) && read_data[0] == !$past(rx_empty);
  endsequence
  property p_rx_reset;
    rx_fifo_reset |-> fifo_enable ##1 !rx_fifo_reset;
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("rx reset without enable");
  property p_tx_reset;
    tx_fifo_reset |-> fifo_enable ##1 !tx_fifo_reset;
  endproperty
  a_tx_reset: assert property (p_tx_reset) else $error("tx reset without enable");
  property p_sleep;
    sleep_enable |-> enh_enable;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep without enhanced mode");
  property p_ls_origin;
    line_status_read |-> !$past(bus_cs_b) && !$past(bus_rd_b) && $past(bus_addr) == 3'h5;
  endproperty
  a_ls_origin: assert property (p_ls_origin) else $error("stray status read");
  property p_ls_answer;
    line_status_read |=> s_answer;
  endproperty
  a_ls_answer: assert property (p_ls_answer) else $error("status read unanswered");
  property p_ls_fields;
    line_status_read |=> s_ls_fields;
  endproperty
  a_ls_fields: assert property (p_ls_fields) else $error("line status fields wrong");
  property p_ms_refused;
    modem_status_read |=> !read_hit;
  endproperty
  a_ms_refused: assert property (p_ms_refused) else $error("modem read answered");
  property p_tx_origin;
    tx_write_pulse |-> !$past(bus_cs_b) && !$past(bus_wr_b) && $past(bus_addr) == 3'h0;
  endproperty
  a_tx_origin: assert property (p_tx_origin) else $error("stray holding write");
  property p_hit_once;
    $rose(read_hit) |=> !read_hit;
  endproperty
  a_hit_once: assert property (p_hit_once) else $error("read answer too long");
endmodule // uip_irq_ctrl_assertions

// ===== uip_host.sv
// host processor model on the parallel register bus
`timescale 1ns/1ns
module uip_host (
  input wire core_clk,
  input wire read_hit,
  input wire [7:0] read_data,
  output logic bus_cs_b = 1'b1,
  output logic bus_rd_b = 1'b1,
  output logic bus_wr_b = 1'b1,
  output logic [2:0] bus_addr = 3'h0,
  output logic [7:0] bus_wdata = 8'h00
);
  // ------------------------------------------------
  // one strobe cycle; no answer on a read leaves q at zero
  // ------------------------------------------------
  task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    q = 8'h00;
    @(posedge core_clk);
    #5;
    bus_addr = a;
    bus_wdata = d;
    bus_cs_b = 1'b0;
    bus_rd_b = wr;
    bus_wr_b = !wr;
    for (n = 0; n < 8; n++)
    begin
      @(posedge core_clk);
      #1;
      if (!wr && read_hit === 1'b1)
      begin
        q = read_data;
        break;
      end
      if (wr && n == 3)
        break;
    end
    #4;
    bus_cs_b = 1'b1;
    bus_rd_b = 1'b1;
    bus_wr_b = 1'b1;
    // released data is scrambled so stale values never look valid
    bus_wdata = ~bus_wdata;
    // strobes must be resampled high before the next access
    repeat (3) @(posedge core_clk);
  endtask
endmodule // uip_host

// ===== uip_irq_ctrl_test.sv
// self-checking testbench of the interrupt prioritizer
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
bind uip_irq_ctrl uip_irq_ctrl_assertions u_chk (.core_clk(core_clk), .rst_b(rst_b),
  .bus_cs_b(bus_cs_b), .bus_rd_b(bus_rd_b), .bus_wr_b(bus_wr_b), .bus_addr(bus_addr),
  .enh_enable(enh_enable), .rx_head_err(rx_head_err), .rx_fifo_err(rx_fifo_err),
  .rx_empty(rx_empty), .thr_empty(thr_empty), .read_data(read_data), .read_hit(read_hit),
  .fifo_enable(fifo_enable), .rx_fifo_reset(rx_fifo_reset), .tx_fifo_reset(tx_fifo_reset),
  .sleep_enable(sleep_enable), .tx_write_pulse(tx_write_pulse),
  .line_status_read(line_status_read), .modem_status_read(modem_status_read));
module uip_irq_ctrl_test;
  logic core_clk = 1'b0, rst_b = 1'b0, enh_enable = 1'b0, auto_cts_en = 1'b0;
  logic auto_rts_en = 1'b0, rx_empty = 1'b1, rx_at_trigger = 1'b0, rx_fifo_err = 1'b0;
  logic thr_empty = 1'b0, tsr_empty = 1'b0, tx_fifo_empty = 1'b0, bit_tick = 1'b0;
  logic tick_on = 1'b0;
  logic [2:0] rx_head_err = 3'h0;
  logic [3:0] modem_delta = 4'h0, char_bits = 4'h2;
  logic [7:0] pv = 8'h00, q;
  wire bus_cs_b, bus_rd_b, bus_wr_b, read_hit, irq, fifo_enable, dma_mode, sleep_enable;
  wire [2:0] bus_addr;
  wire [7:0] bus_wdata, read_data;
  wire [1:0] rx_trig_sel, tx_trig_sel;
  int bad_count = 0, tests_run = 0;
  uip_host u_host (.core_clk(core_clk), .read_hit(read_hit), .read_data(read_data),
    .bus_cs_b(bus_cs_b), .bus_rd_b(bus_rd_b), .bus_wr_b(bus_wr_b), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata));
  uip_irq_ctrl dut (.core_clk(core_clk), .rst_b(rst_b), .ce(1'b1), .bus_cs_b(bus_cs_b),
    .bus_rd_b(bus_rd_b), .bus_wr_b(bus_wr_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .divisor_sel(1'b0), .enh_enable(enh_enable), .auto_cts_en(auto_cts_en),
    .auto_rts_en(auto_rts_en), .rx_char_loaded(pv[0]), .rx_head_load(pv[1]),
    .rx_empty(rx_empty), .rx_at_trigger(rx_at_trigger), .rx_head_err(rx_head_err),
    .rx_fifo_err(rx_fifo_err), .overrun_evt(pv[2]), .thr_empty(thr_empty),
    .tsr_empty(tsr_empty), .tx_below_trigger(1'b0), .tx_fifo_empty(tx_fifo_empty),
    .modem_delta(modem_delta), .xoff_detect(pv[3]), .xon_detect(pv[4]),
    .special_detect(pv[5]), .cts_rise(pv[6]), .rts_rise(pv[7]), .bit_tick(bit_tick),
    .char_bits(char_bits), .read_data(read_data), .read_hit(read_hit), .irq(irq),
    .fifo_enable(fifo_enable), .rx_fifo_reset(), .tx_fifo_reset(), .dma_mode(dma_mode),
    .rx_trig_sel(rx_trig_sel), .tx_trig_sel(tx_trig_sel), .sleep_enable(sleep_enable),
    .rx_read_pulse(), .tx_write_pulse(), .line_status_read(), .modem_status_read());
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  initial
  begin
    forever #25 core_clk = !core_clk;
  end
  always @(posedge core_clk) bit_tick <= #5 tick_on && !bit_tick;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask
  task automatic pulse(input int i);
    pv[i] = 1'b1;
    tick(1);
    pv[i] = 1'b0;
    tick(2);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    u_host.xfer(1'b0, a, 8'h00, q);
    `CHK(q, e)
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ------------------------------------------------
  // tests
  // ------------------------------------------------
  initial
  begin
    tick(4);
    rst_b = 1'b1;
    tick(3);
    rd(3'h2, 8'h01);
    rd(3'h1, 8'h00);
    rd(3'h7, 8'h00);
    wr(3'h1, 8'hf0);
    rd(3'h1, 8'h00);
    enh_enable = 1'b1;
    rd(3'h1, 8'hf0);
    `CHK(sleep_enable, 1'b1)
    enh_enable = 1'b0;
    fin("reset");
    thr_empty = 1'b1;
    tick(4);
    wr(3'h1, 8'h02);
    `CHK(irq, 1'b1)
    rd(3'h2, 8'h02);
    rd(3'h2, 8'h01);
    `CHK(irq, 1'b0)
    thr_empty = 1'b0;
    tick(2);
    thr_empty = 1'b1;
    tick(4);
    `CHK(irq, 1'b1)
    wr(3'h0, 8'h55);
    `CHK(irq, 1'b0)
    fin("transmit");
    wr(3'h1, 8'h0d);
    pulse(2);
    rd(3'h2, 8'h06);
    rx_head_err = 3'h5;
    rx_fifo_err = 1'b1;
    tsr_empty = 1'b1;
    tx_fifo_empty = 1'b1;
    rx_empty = 1'b0;
    // a character must really be loaded for data ready to set
    pulse(0);
    rd(3'h2, 8'h06);
    rd(3'h5, 8'hf7);
    rd(3'h2, 8'h04);
    modem_delta = 4'h2;
    tick(4);
    rd(3'h2, 8'h04);
    rx_empty = 1'b1;
    tick(4);
    rd(3'h2, 8'h00);
    modem_delta = 4'h0;
    tick(4);
    rd(3'h2, 8'h01);
    pulse(1);
    rd(3'h2, 8'h06);
    rd(3'h5, 8'hf4);
    rd(3'h2, 8'h01);
    rx_head_err = 3'h0;
    rx_fifo_err = 1'b0;
    fin("priority");
    wr(3'h2, 8'h07);
    rd(3'h2, 8'hc1);
    wr(3'h2, 8'h06);
    `CHK(fifo_enable, 1'b0)
    rd(3'h2, 8'h01);
    wr(3'h2, 8'h49);
    `CHK({rx_trig_sel, dma_mode, fifo_enable}, 4'h7)
    `CHK(tx_trig_sel, 2'h0)
    wr(3'h1, 8'h00);
    rx_empty = 1'b0;
    rx_at_trigger = 1'b1;
    tick(4);
    rd(3'h2, 8'hc1);
    `CHK(irq, 1'b0)
    wr(3'h1, 8'h01);
    rd(3'h2, 8'hc4);
    rx_at_trigger = 1'b0;
    tick(4);
    rd(3'h2, 8'hc1);
    fin("fifo");
    tick_on = 1'b1;
    pulse(0);
    tick(25);
    `CHK(irq, 1'b0)
    tick(25);
    `CHK(irq, 1'b1)
    rd(3'h2, 8'hcc);
    rd(3'h0, 8'h00);
    rd(3'h2, 8'hc1);
    tick_on = 1'b0;
    rx_empty = 1'b1;
    fin("timeout");
    enh_enable = 1'b1;
    wr(3'h1, 8'he0);
    pulse(3);
    rd(3'h2, 8'hd0);
    rd(3'h2, 8'hc1);
    pulse(3);
    pulse(4);
    rd(3'h2, 8'hc1);
    pulse(5);
    `CHK(irq, 1'b1)
    pulse(0);
    rd(3'h2, 8'hc1);
    pulse(6);
    rd(3'h2, 8'hc1);
    auto_cts_en = 1'b1;
    pulse(6);
    rd(3'h2, 8'he0);
    rd(3'h2, 8'he0);
    u_host.xfer(1'b0, 3'h6, 8'h00, q);
    rd(3'h2, 8'hc1);
    auto_rts_en = 1'b1;
    pulse(7);
    rd(3'h2, 8'he0);
    u_host.xfer(1'b0, 3'h6, 8'h00, q);
    rd(3'h2, 8'hc1);
    wr(3'h2, 8'h19);
    `CHK({tx_trig_sel, rx_trig_sel}, 4'h4)
    fin("enhanced");
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    report_and_stop();
  end
endmodule // uip_irq_ctrl_test
